// >>> logic/afhp_pkg.sv
package afhp_pkg;
  // ------------------------------------------------------------
  // widths and depth
  // ------------------------------------------------------------
  localparam int DATA_W      = 12;
  localparam int FIFO_DEPTH  = 16;
  localparam int CNT_W       = 5;
  localparam int ADDR_W      = 4;
  // ------------------------------------------------------------
  // second control register field positions and reset values
  // ------------------------------------------------------------
  localparam int THR_LO_BIT  = 2;
  localparam int THR_HI_BIT  = 3;
  localparam int TYPE_BIT    = 4;
  localparam int POL_BIT     = 5;
  localparam int DIR_BIT     = 6;
  localparam int FRST_BIT    = 1;
  localparam logic [1:0] THR_RST  = 2'h0;
  localparam logic       TYPE_RST = 1'h1;
  localparam logic       POL_RST  = 1'h1;
  localparam logic       DIR_RST  = 1'h0;
  // ------------------------------------------------------------
  // threshold tables, one and two channels
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] THR1_0 = 5'h01;
  localparam logic [CNT_W-1:0] THR1_1 = 5'h04;
  localparam logic [CNT_W-1:0] THR1_2 = 5'h08;
  localparam logic [CNT_W-1:0] THR1_3 = 5'h0e;
  localparam logic [CNT_W-1:0] THR2_0 = 5'h02;
  localparam logic [CNT_W-1:0] THR2_1 = 5'h04;
  localparam logic [CNT_W-1:0] THR2_2 = 5'h08;
  localparam logic [CNT_W-1:0] THR2_3 = 5'h0c;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic [DATA_W-1:0] data;
  } afhp_sample_t;
  typedef struct packed {
    logic       dir_mode;
    logic       pol_high;
    logic       pulse_type;
    logic [1:0] thr_code;
  } afhp_cfg_t;
  typedef enum logic [1:0] {
    AFHP_IDLE  = 2'b00,
    AFHP_ARMED = 2'b01,
    AFHP_DRAIN = 2'b10
  } afhp_state_t;
endpackage

// >>> logic/afhp_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module afhp_fifo_mem #(
  parameter int DW = 12,
  parameter int AW = 4
) (
  // clock
  input  wire logic          clk_in,
  // write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [DW-1:0] wr_data_in,
  // read port
  input  wire logic          rd_en_in,
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule
`default_nettype wire

// >>> logic/afhp_top.sv
// Functional notes
// R1 - threshold from bits 3:2 of second control register; flag when count reaches it
// R2 - one channel: codes 0..3 give thresholds 1, 4, 8, 14
// R3 - two channels: codes 0..3 give thresholds 2, 4, 8, 12
// R4 - each input is one channel; results leave fifo in fixed channel order
// R5 - read strobe needs both selects and read, write idle; pops word, drives bus
// R6 - write strobe needs both selects and write, read idle; loads addressed register
// R7 - write input can become a combined read/write direction line
// R8 - polarity and type bits: 00 low level, 01 low pulse, 10 high level, 11 high pulse
// R9 - flag goes active when threshold met; return depends on level or pulse
// R10 - level form: inactive at first of threshold reads; recheck after that many reads
// R11 - host should pick level form in single conversion mode
// R12 - pulse form lasts half a sample pace clock period
// R13 - next pulse only after threshold reads done and condition holds again
// R14 - host ties read input high in combined direction mode
// R15 - bit 6 selects direction-line scheme; read input then ignored
// R16 - first select active low, second select active high
// R17 - fifo holds sixteen words; compare uses unread word count
`timescale 1ns/1ps
`default_nettype none
module afhp_top
#(
  parameter int DW    = afhp_pkg::DATA_W,
  parameter int DEPTH = afhp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // processor bus pins
  input  wire logic                   select_low_n_in,
  input  wire logic                   select_high_in,
  input  wire logic                   read_n_in,
  input  wire logic                   write_n_in,
  input  wire logic                   reg_addr_in,
  input  wire logic [DW-1:0]          bus_data_in,
  output logic      [DW-1:0]          bus_data_out,
  output logic                        bus_data_oe_out,
  // converter side
  input  wire logic                   sample_pace_clock_in,
  input  wire afhp_pkg::afhp_sample_t sample_in,
  input  wire logic                   two_channel_in,
  // status and configuration view
  output logic                        words_ready_flag_out,
  output afhp_pkg::afhp_cfg_t         cfg_out,
  output logic [afhp_pkg::CNT_W-1:0]  fill_count_out,
  output logic                        overflow_out,
  output logic [DW-1:0]               ctrl0_out
);
  import afhp_pkg::*;
  // ------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];
  // data and address ride through the same stages as the strobes
  logic [DW+5:0] pin_s1_ff;
  logic [DW+5:0] pin_s2_ff;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= {{(DW+1){1'b0}}, 5'h0d};
      pin_s2_ff <= {{(DW+1){1'b0}}, 5'h0d};
    end else begin
      pin_s1_ff <= {reg_addr_in, bus_data_in, sample_pace_clock_in, read_n_in, write_n_in,
                    select_high_in, select_low_n_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  logic sel_lo_n;
  logic sel_hi;
  logic wr_n;
  logic rd_n;
  logic pace;
  assign sel_lo_n = pin_s2_ff[0];
  assign sel_hi   = pin_s2_ff[1];
  assign wr_n     = pin_s2_ff[2];
  assign rd_n     = pin_s2_ff[3];
  assign pace     = pin_s2_ff[4];
  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------
  afhp_cfg_t cfg_ff;
  logic      both_sel;
  logic      rd_strobe;
  logic      wr_strobe;
  assign both_sel  = !sel_lo_n && sel_hi;                              // R16
  // direction line high reads, low writes; read pin ignored
  assign rd_strobe = both_sel && (cfg_ff.dir_mode ? wr_n                // R7 R15 R14
                                                  : (!rd_n && wr_n));  // R5
  assign wr_strobe = both_sel && (cfg_ff.dir_mode ? !wr_n
                                                  : (!wr_n && rd_n));  // R6
  logic rd_strobe_ff;
  logic wr_strobe_ff;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe_ff <= 1'b0;
      wr_strobe_ff <= 1'b0;
    end else begin
      rd_strobe_ff <= rd_strobe;
      wr_strobe_ff <= wr_strobe;
    end
  end
  logic rd_start;
  logic wr_end;
  assign rd_start = rd_strobe && !rd_strobe_ff;                         // R5
  assign wr_end   = !wr_strobe && wr_strobe_ff;
  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [DW-1:0] wr_word_ff;
  logic          wr_addr_ff;
  logic [DW-1:0] ctrl0_ff;
  logic          fifo_clear;
  assign fifo_clear = wr_end && wr_addr_ff && wr_word_ff[FRST_BIT];
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_word_ff <= '0;
      wr_addr_ff <= 1'b0;
      ctrl0_ff   <= '0;
      cfg_ff     <= '{DIR_RST, POL_RST, TYPE_RST, THR_RST};
    end else begin
      if (wr_strobe) begin
        wr_word_ff <= pin_s2_ff[DW+4:5];
        wr_addr_ff <= pin_s2_ff[DW+5];
      end
      if (wr_end && !wr_addr_ff) begin
        ctrl0_ff <= wr_word_ff;                                          // R6
      end
      if (wr_end && wr_addr_ff) begin
        cfg_ff.dir_mode   <= wr_word_ff[DIR_BIT];                       // R15
        cfg_ff.pol_high   <= wr_word_ff[POL_BIT];                       // R8
        cfg_ff.pulse_type <= wr_word_ff[TYPE_BIT];                      // R8
        cfg_ff.thr_code   <= wr_word_ff[THR_HI_BIT:THR_LO_BIT];         // R1
      end
    end
  end

  // ------------------------------------------------------------
  // result fifo
  // ------------------------------------------------------------
  logic [ADDR_W-1:0] wr_ptr_ff;
  logic [ADDR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0]  count_ff;
  logic              ovfl_ff;
  logic              push;
  logic              pop;
  logic              full;
  assign full = (count_ff == CNT_W'(DEPTH));                            // R17
  assign push = sample_in.valid && !full;                               // R4
  assign pop  = rd_start && (count_ff != '0);                           // R5
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ovfl_ff   <= 1'b0;
    end else if (fifo_clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ovfl_ff   <= sample_in.valid && full;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + CNT_W'(push) - CNT_W'(pop);                // R17
      if (sample_in.valid && full) begin
        ovfl_ff <= 1'b1;
      end
    end
  end

  logic [DW-1:0] mem_rd_data;
  afhp_fifo_mem #(
    .DW (DW),
    .AW (ADDR_W)
  ) u_mem (
    .clk_in      (clk_in),
    .wr_en_in    (push),
    .wr_addr_in  (wr_ptr_ff),
    .wr_data_in  (sample_in.data),
    .rd_en_in    (pop),
    .rd_addr_in  (rd_ptr_ff),
    .rd_data_out (mem_rd_data)
  );

  // ------------------------------------------------------------
  // threshold selection
  // ------------------------------------------------------------
  logic [CNT_W-1:0] thr_one;
  logic [CNT_W-1:0] thr_two;
  logic [CNT_W-1:0] thr_level;
  assign thr_one = (cfg_ff.thr_code == 2'h0) ? THR1_0 :
                   (cfg_ff.thr_code == 2'h1) ? THR1_1 :
                   (cfg_ff.thr_code == 2'h2) ? THR1_2 : THR1_3;         // R2
  assign thr_two = (cfg_ff.thr_code == 2'h0) ? THR2_0 :
                   (cfg_ff.thr_code == 2'h1) ? THR2_1 :
                   (cfg_ff.thr_code == 2'h2) ? THR2_2 : THR2_3;         // R3
  assign thr_level = two_channel_in ? thr_two : thr_one;
  logic thr_met;
  assign thr_met = (count_ff >= thr_level);                             // R1

  // ------------------------------------------------------------
  // data-available sequencer
  // ------------------------------------------------------------
  afhp_state_t      state_ff;
  afhp_state_t      nxt_state;
  logic [CNT_W-1:0] reads_left_ff;
  logic [CNT_W-1:0] nxt_reads_left;
  logic             active_ff;
  logic             nxt_active;
  logic             pace_ff;
  logic             pace_edge;
  assign pace_edge = (pace != pace_ff);
  always_comb begin
    nxt_state      = state_ff;
    nxt_reads_left = reads_left_ff;
    nxt_active     = active_ff;
    case (state_ff)
      AFHP_IDLE: begin
        if (thr_met) begin
          nxt_state      = AFHP_ARMED;
          nxt_active     = 1'b1;                                         // R9
          nxt_reads_left = thr_level;
        end
      end
      AFHP_ARMED: begin
        // pulse ends on next half period of the pace clock
        if (cfg_ff.pulse_type && pace_edge) begin
          nxt_active = 1'b0;                                             // R12
        end
        if (pop) begin
          nxt_active     = 1'b0;                                         // R10
          nxt_state      = AFHP_DRAIN;
          nxt_reads_left = reads_left_ff - 1'b1;
        end
      end
      AFHP_DRAIN: begin
        if (pop) begin
          nxt_reads_left = reads_left_ff - 1'b1;
        end
        if ((reads_left_ff == '0) || fifo_clear) begin
          nxt_state = AFHP_IDLE;                                         // R10 R13
        end
      end
      default: begin
        nxt_state  = AFHP_IDLE;
        nxt_active = 1'b0;
      end
    endcase
    if (fifo_clear) begin
      nxt_state  = AFHP_IDLE;
      nxt_active = 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff      <= AFHP_IDLE;
      reads_left_ff <= '0;
      active_ff     <= 1'b0;
      pace_ff       <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      reads_left_ff <= nxt_reads_left;
      active_ff     <= nxt_active;
      pace_ff       <= pace;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic flag_ff;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= !POL_RST;
    end else begin
      flag_ff <= cfg_ff.pol_high ? nxt_active : !nxt_active;            // R8
    end
  end
  assign words_ready_flag_out = flag_ff;
  assign bus_data_out         = mem_rd_data;
  assign bus_data_oe_out      = rd_strobe_ff;                            // R5
  assign cfg_out              = cfg_ff;
  assign fill_count_out       = count_ff;
  assign overflow_out         = ovfl_ff;
  assign ctrl0_out            = ctrl0_ff;
endmodule
`default_nettype wire

// >>> tb/afhp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module afhp_top_asserts (
  // pins
  input wire logic                       clk_in,
  input wire logic                       arst_n_in,
  input wire logic                       select_low_n_in,
  input wire logic                       select_high_in,
  input wire logic                       read_n_in,
  input wire logic                       write_n_in,
  input wire logic                       sample_pace_clock_in,
  input wire afhp_pkg::afhp_sample_t     sample_in,
  input wire logic                       two_channel_in,
  // outputs
  input wire logic                       bus_data_oe_out,
  input wire logic                       words_ready_flag_out,
  input wire afhp_pkg::afhp_cfg_t        cfg_out,
  input wire logic [afhp_pkg::CNT_W-1:0] fill_count_out,
  input wire logic                       overflow_out
);
  import afhp_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------
  // pin decode
  // ----------------
  wire logic             sel_w = !select_low_n_in && select_high_in;
  wire logic             rd_w  = sel_w && write_n_in && (cfg_out.dir_mode || !read_n_in);
  wire logic             wr_w  = sel_w && !write_n_in && (cfg_out.dir_mode || read_n_in);
  wire logic             act_w = words_ready_flag_out == cfg_out.pol_high;
  wire logic [CNT_W-1:0] thr_w = cfg_out.thr_code[1] ?
    (cfg_out.thr_code[0] ? (two_channel_in ? THR2_3 : THR1_3) : THR1_2) :
    (cfg_out.thr_code[0] ? THR1_1 : (two_channel_in ? THR2_0 : THR1_0));
  // ----------------
  // properties
  // ----------------
  sequence s_both_held;
    (sel_w && !read_n_in && !write_n_in && !cfg_out.dir_mode)[*5];
  endsequence
  sequence s_pop;
    $rose(bus_data_oe_out) && $past(fill_count_out) != 5'h0 && !$past(sample_in.valid);
  endsequence
  property p_oe_cause;
    $rose(bus_data_oe_out) |-> $past(rd_w, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drivers on without read");
  property p_oe_drop;
    $fell(rd_w) |-> ##[1:6] !bus_data_oe_out;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("drivers stay on");
  property p_pop;
    s_pop |-> fill_count_out == $past(fill_count_out) - 5'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not pop one word");
  property p_refuse;
    s_both_held |-> !bus_data_oe_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read with write active");
  property p_cfg_src;
    !$stable(cfg_out) |-> $past(wr_w, 6);
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("config changed without write");
  property p_flag_thr;
    ($rose(act_w) && $stable(cfg_out)) |-> $past(fill_count_out) >= $past(thr_w);
  endproperty
  a_flag_thr: assert property (p_flag_thr) else $error("flag below threshold");
  property p_lvl_drop;
    (act_w && !cfg_out.pulse_type && $rose(rd_w)) |-> ##[1:4] !act_w;
  endproperty
  a_lvl_drop: assert property (p_lvl_drop) else $error("level flag kept on read");
  property p_pulse_end;
    (act_w && cfg_out.pulse_type && $changed(sample_pace_clock_in)) |-> ##[1:12] !act_w;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse too long");
  property p_ovf;
    $rose(overflow_out) |-> $past(fill_count_out) == 5'h10;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow while not full");
endmodule
bind afhp_top afhp_top_asserts u_asserts (.clk_in, .arst_n_in, .select_low_n_in,
  .select_high_in, .read_n_in, .write_n_in, .sample_pace_clock_in, .sample_in,
  .two_channel_in, .bus_data_oe_out, .words_ready_flag_out, .cfg_out, .fill_count_out,
  .overflow_out);
`default_nettype wire

// >>> tb/afhp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module afhp_host_model
  import afhp_pkg::*;
(
  // clock and read data
  input  wire logic              clk_in,
  input  wire logic [DATA_W-1:0] rd_data_in,
  // bus pins
  output logic                   sel_low_n_out,
  output logic                   sel_high_out,
  output logic                   read_n_out,
  output logic                   write_n_out,
  output logic                   addr_out,
  output logic [DATA_W-1:0]      data_out
);
  logic dir_mode = 1'b0;
  initial begin
    sel_low_n_out = 1'b1;
    sel_high_out = 1'b0;
    read_n_out = 1'b1;
    write_n_out = 1'b1;
    addr_out = 1'b0;
    data_out = '0;
  end
  // kind 0 read, 1 write, 2 read and write together
  task automatic xfer(input logic [1:0] kind, input logic a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    @(posedge clk_in);
    sel_low_n_out <= 1'b0;
    sel_high_out <= 1'b1;
    addr_out <= a;
    data_out <= d;
    read_n_out <= dir_mode ? (kind != 2'h2) : (kind == 2'h1);
    write_n_out <= (kind == 2'h0);
    repeat (5) @(posedge clk_in);
    q = rd_data_in;
    sel_low_n_out <= 1'b1;
    sel_high_out <= 1'b0;
    read_n_out <= 1'b1;
    write_n_out <= 1'b1;
    data_out <= ~d;
    repeat (6) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/afhp_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module afhp_top_tb_top;
  import afhp_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              pace = 1'b0;
  logic              two = 1'b0;
  logic [2:0]        pcnt = 3'h0;
  afhp_sample_t      smp = '0;
  logic              sel_n, sel_h, rd_n, wr_n, addr, flag, oe, ovf;
  logic [DATA_W-1:0] wdata, rdata, ctrl0, q;
  afhp_cfg_t         cfg;
  logic [CNT_W-1:0]  cnt;
  logic [7:0]        rows [8] = '{8'h01, 8'h24, 8'h48, 8'h6e, 8'h82, 8'ha4, 8'hc8, 8'hec};
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                cyc = 0;
  wire logic         act = (flag === cfg.pol_high);
  afhp_top DUT (.clk_in(clk), .arst_n_in(arst_n), .select_low_n_in(sel_n),
    .select_high_in(sel_h), .read_n_in(rd_n), .write_n_in(wr_n), .reg_addr_in(addr),
    .bus_data_in(wdata), .bus_data_out(rdata), .bus_data_oe_out(oe),
    .sample_pace_clock_in(pace), .sample_in(smp), .two_channel_in(two),
    .words_ready_flag_out(flag), .cfg_out(cfg), .fill_count_out(cnt),
    .overflow_out(ovf), .ctrl0_out(ctrl0));
  afhp_host_model u_host (.clk_in(clk), .rd_data_in(rdata), .sel_low_n_out(sel_n),
    .sel_high_out(sel_h), .read_n_out(rd_n), .write_n_out(wr_n), .addr_out(addr),
    .data_out(wdata));
  // ----------------
  // clocks and limit
  // ----------------
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    pcnt <= pcnt + 3'h1;
    if (pcnt == 3'h7) pace <= ~pace;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      $display("ERROR %0t timeout", $time);
      summarize();
    end
  end
  // ----------------
  // tasks
  // ----------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task push(input logic [DATA_W-1:0] d);
    @(posedge clk);
    smp <= {1'b1, d};
    @(posedge clk);
    smp.valid <= 1'b0;
  endtask
  task cfgw(input logic dir, input logic pol, input logic typ, input logic [1:0] code);
    u_host.xfer(2'h1, 1'b1, {5'h00, dir, pol, typ, code, 2'b10}, q);
  endtask
  task wait_act(input logic e, input int n, input logic want);
    for (int i = 0; i < n && act !== e; i++) @(posedge clk);
    chk(16'(act), 16'(want));
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    foreach (rows[r]) begin
      @(posedge clk);
      two <= rows[r][7];
      cfgw(1'b0, rows[r][5], 1'b0, rows[r][6:5]);
      chk(16'(cfg), 16'({1'b0, rows[r][5], 1'b0, rows[r][6:5]}));
      repeat (int'(rows[r][4:0]) - 1) push(12'(r));
      wait_act(1'b1, 4, 1'b0);
      push(12'h0ff);
      wait_act(1'b1, 4, 1'b1);
      u_host.xfer(2'h0, 1'b0, 12'h000, q);
      chk(16'(cnt), 16'(rows[r][4:0] - 5'h1));
      chk(16'(act), 16'h0);
      $display("row %0d done", r);
    end
    cfgw(1'b0, 1'b1, 1'b0, 2'h3);
    push(12'ha01);
    push(12'hb02);
    push(12'hc03);
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(2'h0, 1'b0, 12'h000, q);
      chk(16'(q), 16'(12'ha01 + 12'(i) * 12'h101));
    end
    u_host.xfer(2'h0, 1'b0, 12'h000, q);
    chk(16'(cnt), 16'h0);
    u_host.xfer(2'h1, 1'b0, 12'h3c5, q);
    chk(16'(ctrl0), 16'h3c5);
    $display("order test done");
    repeat (17) push(12'h111);
    @(posedge clk);
    chk(16'(cnt), 16'h10);
    chk(16'(ovf), 16'h1);
    u_host.xfer(2'h2, 1'b1, 12'h026, q);
    chk(16'(cfg), 16'h0b);
    chk(16'(cnt), 16'h10);
    $display("overflow and refusal test done");
    @(posedge clk);
    two <= 1'b0;
    cfgw(1'b0, 1'b0, 1'b1, 2'h0);
    push(12'h001);
    wait_act(1'b1, 6, 1'b1);
    wait_act(1'b0, 14, 1'b0);
    push(12'h002);
    wait_act(1'b1, 14, 1'b0);
    fork
      u_host.xfer(2'h0, 1'b0, 12'h000, q);
      wait_act(1'b1, 14, 1'b1);
    join
    $display("pulse test done");
    cfgw(1'b1, 1'b1, 1'b0, 2'h0);
    chk(16'(cfg.dir_mode), 16'h1);
    u_host.dir_mode = 1'b1;
    push(12'h5a5);
    u_host.xfer(2'h0, 1'b0, 12'h000, q);
    chk(16'(q), 16'h5a5);
    u_host.xfer(2'h2, 1'b1, {5'h00, 3'b110, 2'h2, 2'b00}, q);
    chk(16'(cfg), 16'h1a);
    $display("direction test done");
    @(posedge clk);
    arst_n <= 1'b0;
    u_host.dir_mode = 1'b0;
    repeat (2) @(posedge clk);
    chk(16'(cfg), 16'h0c);
    chk(16'({cnt, flag, oe}), 16'h0);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(16'({cnt, flag, oe}), 16'h0);
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
